/* File: src/sss_ctrl.sv */
// soft stop ramp and dedicated start input handling
// Behaviour
// - soft stop ramps to start velocity, then halts
// - soft stop leaves running sequence untouched
// - soft stop from immediate, sequence, network
// - mode 0: start begins sequence, resumes pause
// - mode 1: level; clearing aborts sequence, motion
module sss_ctrl
  import sss_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = sss_pkg::TD_UNIT_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // soft stop sources
  input wire logic ss_imm,
  input wire logic ss_seq,
  input wire logic ss_net,
  // motion settings and requests
  input wire logic [sss_pkg::VEL_W-1:0] start_velocity,
  input wire logic [sss_pkg::TD_W-1:0] decel_time,
  input wire logic [sss_pkg::VEL_W-1:0] run_velocity,
  input wire logic move_start,
  input wire logic pause_cmd,
  // pins
  input wire logic start_pin,
  input wire logic pause_pin,
  // start action setting
  input wire logic action_wr,
  input wire logic action_val,
  // sequence engine
  input wire logic seq_done,
  output logic seq_running,
  output logic seq_start,
  output logic seq_abort,
  // motor side
  output logic [sss_pkg::VEL_W-1:0] vel_out,
  output logic moving,
  output logic start_input_action
);
  import sss_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    sss_state_e st;
    logic [VEL_W-1:0] vel;
    logic [VEL_W-1:0] vs;
    logic [VEL_W-1:0] step;
    logic [VEL_W-1:0] paused_vel;
    logic [TD_W-1:0] td_left;
    logic [CNT_W-1:0] tick_cnt;
    logic action;
    logic start_prev;
    logic pause_prev;
    logic seq_run;
    logic seq_start;
    logic seq_abort;
  } sss_regs_s;

  sss_regs_s q, d;
  logic start_s, pause_s;
  logic ss_any, tick, start_rise, start_fall, pause_rise, abort_lvl;
  logic [VEL_W-1:0] diff, next_vel;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  sss_sync #(.W(2)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({start_pin, pause_pin}),
    .q({start_s, pause_s})
  );

  assign ss_any = ss_imm | ss_seq | ss_net;
  assign tick = (q.tick_cnt == '0);
  assign start_rise = start_s & ~q.start_prev;
  assign start_fall = ~start_s & q.start_prev;
  assign pause_rise = pause_cmd | (pause_s & ~q.pause_prev);
  assign abort_lvl = (q.action == ACT_LEVEL) && start_fall && q.seq_run;
  assign diff = (q.vel > start_velocity) ? q.vel - start_velocity : '0;
  assign next_vel = (q.vel - q.step > q.vs && q.vel > q.step) ? q.vel - q.step : q.vs;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.seq_start = 1'b0;
    d.seq_abort = 1'b0;
    d.start_prev = start_s;
    d.pause_prev = pause_s;
    d.tick_cnt = tick ? CNT_W'(TICK_CYCLES - 1) : q.tick_cnt - 1'b1;
    if (action_wr) begin
      d.action = action_val;
    end
    if (seq_done) begin
      d.seq_run = 1'b0;
    end
    if (start_rise && !q.seq_run) begin
      d.seq_run = 1'b1;
      d.seq_start = 1'b1;
    end
    case (q.st)
      SSS_IDLE: begin
        if (move_start && !ss_any) begin
          d.st = SSS_RUN;
          d.vel = run_velocity;
        end
      end
      SSS_RUN: begin
        if (ss_any) begin
          // ramp slope fixed at entry; zero decel time stops at once
          d.vs = start_velocity;
          d.td_left = decel_time;
          d.step = (decel_time == '0) ? diff : diff / decel_time;
          d.tick_cnt = CNT_W'(TICK_CYCLES - 1);
          d.st = SSS_DECEL;
          if (q.vel <= start_velocity || decel_time == '0) begin
            d.st = SSS_IDLE;
            d.vel = '0;
          end
        end else if (pause_rise) begin
          d.st = SSS_PAUSED;
          d.paused_vel = q.vel;
          d.vel = '0;
        end
      end
      SSS_DECEL: begin
        if (q.td_left == '0) begin
          // ramp has landed on start velocity: halt
          d.st = SSS_IDLE;
          d.vel = '0;
        end else if (tick) begin
          // last tick lands exactly on start velocity, absorbing the remainder
          d.td_left = q.td_left - 1'b1;
          d.vel = (q.td_left == TD_W'(1)) ? q.vs : next_vel;
        end
      end
      SSS_PAUSED: begin
        if (ss_any) begin
          d.st = SSS_IDLE;
        end else if (q.action == ACT_START_RESUME && q.seq_run && start_rise) begin
          d.st = SSS_RUN;
          d.vel = q.paused_vel;
        end
      end
      default: begin
        d.st = SSS_IDLE;
        d.vel = '0;
      end
    endcase
    if (abort_lvl) begin
      d.seq_run = 1'b0;
      d.seq_abort = 1'b1;
      d.st = SSS_IDLE;
      d.vel = '0;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '{st: SSS_IDLE, action: ACT_RESET, default: '0};
    end else begin
      q <= d;
    end
  end

  assign vel_out = q.vel;
  assign moving = (q.st == SSS_RUN) || (q.st == SSS_DECEL);
  assign seq_running = q.seq_run;
  assign seq_start = q.seq_start;
  assign seq_abort = q.seq_abort;
  assign start_input_action = q.action;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence ss_in_run;
    q.st == SSS_RUN && ss_any && !abort_lvl;
  endsequence

  sequence decel_land;
    q.st == SSS_DECEL && tick && q.td_left == TD_W'(1) && !abort_lvl;
  endsequence

  sequence decel_last;
    q.st == SSS_DECEL && q.td_left == '0 && !abort_lvl;
  endsequence

  soft_stop_cmd_enter_a: assert property (ss_in_run |=> q.st != SSS_RUN && q.st != SSS_PAUSED)
    else $error("soft stop did not leave run");
  decel_floor_a: assert property (q.st == SSS_DECEL |-> q.vel >= q.vs
    && (q.vel > q.vs || q.td_left == '0))
    else $error("ramp fell below start velocity");
  decel_land_a: assert property (decel_land |=> vel_out == q.vs ##1 !moving)
    else $error("ramp did not land on start velocity");
  decel_end_a: assert property (decel_last |=> q.st == SSS_IDLE
    && vel_out == '0 && !moving)
    else $error("motor not halted at end of ramp");
  seq_kept_a: assert property (q.seq_run && ss_any && !seq_done && !abort_lvl
    |=> q.seq_run)
    else $error("soft stop ended the sequence");
  start_seq_a: assert property (start_rise && !q.seq_run
    |=> seq_start && seq_running ##1 !seq_start)
    else $error("start input did not begin sequence");
  resume_a: assert property (q.st == SSS_PAUSED && q.action == ACT_START_RESUME
    && q.seq_run && start_rise && !ss_any
    |=> q.st == SSS_RUN && vel_out == $past(q.paused_vel))
    else $error("paused motion not resumed");
  level_abort_a: assert property ($fell(start_s) && q.action == ACT_LEVEL && q.seq_run
    |=> seq_abort && !seq_running && vel_out == '0)
    else $error("clearing start did not abort");
  action_load_a: assert property (action_wr |=> start_input_action == $past(action_val))
    else $error("start action setting not stored");
endmodule

/* File: src/sss_pkg.sv */
// constants shared by the soft stop and start input logic
package sss_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int VEL_W = 16;
  localparam int TD_W = 16;
  localparam int CNT_W = 16;
  // ---------------------------------------------------------------
  // timing: clock period and the unit of the decel time setting
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TD_UNIT_NS = 1000000;
  localparam int TD_UNIT_CYCLES = TD_UNIT_NS / CLK_PERIOD_NS;
  // ---------------------------------------------------------------
  // start input action modes
  // ---------------------------------------------------------------
  localparam logic ACT_START_RESUME = 1'b0;
  localparam logic ACT_LEVEL = 1'b1;
  localparam logic ACT_RESET = ACT_START_RESUME;
  // ---------------------------------------------------------------
  // motion states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SSS_IDLE,
    SSS_RUN,
    SSS_DECEL,
    SSS_PAUSED
  } sss_state_e;
endpackage

/* File: src/sss_sync.sv */
// two flip-flop synchroniser for pin inputs
module sss_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

/* File: test/sss_ctrl_tb.sv */
// self-checking bench for the soft stop and start input logic
module sss_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sss_pkg::*;
  logic clk, rst, ss_imm, ss_seq, ss_net, move_start, pause_cmd, start_pin, pause_pin;
  logic action_wr, action_val, seq_done, seq_running, seq_start, seq_abort, moving;
  logic start_input_action, done_en;
  logic [VEL_W-1:0] start_velocity, run_velocity, vel_out;
  logic [TD_W-1:0] decel_time;
  int failures, comparisons;
  sss_ctrl #(.TICK_CYCLES(4)) u_dut (.clk, .rst, .ss_imm, .ss_seq, .ss_net,
    .start_velocity, .decel_time, .run_velocity, .move_start, .pause_cmd, .start_pin,
    .pause_pin, .action_wr, .action_val, .seq_done, .seq_running, .seq_start, .seq_abort,
    .vel_out, .moving, .start_input_action);
  sss_seq_model u_seq (.clk, .rst, .enable(done_en), .seq_done);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic sig(input int i);
    case (i)
      0: return seq_start;
      1: return seq_abort;
      default: return !seq_running;
    endcase
  endfunction
  task automatic wait_sig(input int i);
    int n;
    n = 0;
    while (sig(i) !== 1'b1 && n < 12) begin
      @(negedge clk);
      n++;
    end
    if (n == 12) begin
      chk("wait_timeout", 16'h0, 16'h1);
      tally_and_finish();
    end
  endtask
  task automatic pulse(input int i);
    {ss_imm, ss_seq, ss_net, move_start, pause_cmd, action_wr} = 6'h20 >> i;
    @(negedge clk);
    {ss_imm, ss_seq, ss_net, move_start, pause_cmd, action_wr} = 6'h0;
    // idle cycle so back-to-back pulses never reassign in one step
    @(negedge clk);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic start_resume();
    start_pin = 1'b1;
    wait_sig(0);
    chk("seq_running", 16'h1, 16'(seq_running));
    @(negedge clk);
    pulse(3);
    pulse(4);
    chk("paused_moving", 16'h0, 16'(moving));
    start_pin = 1'b0;
    repeat (5) @(negedge clk);
    start_pin = 1'b1;
    repeat (6) @(negedge clk);
    chk("resume_moving", 16'h1, 16'(moving));
    chk("resume_vel", 16'h64, vel_out);
    pause_pin = 1'b1;
    repeat (4) @(negedge clk);
    chk("pin_paused", 16'h0, 16'(moving));
    {pause_pin, start_pin} = 2'b00;
    repeat (3) @(negedge clk);
    start_pin = 1'b1;
    repeat (6) @(negedge clk);
    chk("pin_resume_moving", 16'h1, 16'(moving));
    chk("pin_resume_vel", 16'h64, vel_out);
  endtask
  task automatic soft_stop(input int src);
    int n;
    logic [15:0] prev;
    if (moving !== 1'b1) pulse(3);
    chk("run_vel", 16'h64, vel_out);
    pulse(src);
    prev = vel_out;
    n = 0;
    while (moving === 1'b1 && n < 40) begin
      chk("ramp_step", 16'h1, 16'(vel_out <= prev && vel_out >= 16'h14));
      prev = vel_out;
      n++;
      @(negedge clk);
    end
    if (n == 40) begin
      chk("ramp_timeout", 16'h0, 16'h1);
      tally_and_finish();
    end
    chk("ramp_len", 16'h10, 16'(n));
    chk("vel_at_vs", 16'h14, prev);
    chk("vel_stop", 16'h0, vel_out);
    chk("seq_kept", 16'h1, 16'(seq_running));
  endtask
  task automatic level_mode();
    start_pin = 1'b0;
    done_en = 1'b1;
    wait_sig(2);
    done_en = 1'b0;
    action_val = 1'b1;
    pulse(5);
    chk("action", 16'h1, 16'(start_input_action));
    start_pin = 1'b1;
    wait_sig(0);
    chk("level_start", 16'h1, 16'(seq_running));
    @(negedge clk);
    pulse(3);
    chk("level_move", 16'h1, 16'(moving));
    start_pin = 1'b0;
    wait_sig(1);
    chk("abort_run", 16'h0, 16'(seq_running));
    chk("abort_move", 16'h0, 16'(moving));
    chk("abort_vel", 16'h0, vel_out);
  endtask
  // ---------------------------------------------------------------
  // clock, reset and sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    failures = 0;
    comparisons = 0;
    rst = 1'b1;
    {ss_imm, ss_seq, ss_net, move_start, pause_cmd, action_wr} = 6'h0;
    {start_pin, pause_pin, action_val, done_en} = 4'h0;
    start_velocity = 16'h14;
    run_velocity = 16'h64;
    decel_time = 16'h4;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("action_reset", 16'h0, 16'(start_input_action));
    chk("vel_reset", 16'h0, vel_out);
    start_resume();
    for (int s = 0; s < 3; s++) soft_stop(s);
    level_mode();
    tally_and_finish();
  end
endmodule

/* File: test/sss_seq_model.sv */
// sequence engine model: ends the running sequence when the host allows it
module sss_seq_model #(
  parameter int DONE_CYCLES = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host permission to end the sequence
  input wire logic enable,
  // end report to the block
  output logic seq_done
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  logic en_q;
  // ---------------------------------------------------------------
  // one-cycle end pulse a fixed time after permission rises
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      en_q <= 1'b0;
      seq_done <= 1'b0;
    end else begin
      en_q <= enable;
      seq_done <= (cnt == 1);
      if (enable && !en_q) begin
        cnt <= DONE_CYCLES;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
